// [verilog/audio_stream_regs.svh]
// constants for the audio serial stream control block
`ifndef AUDIO_STREAM_REGS_SVH
`define AUDIO_STREAM_REGS_SVH
// control field positions
`define CTL_ON_BIT 15
`define CTL_MASTER_BIT 5
`define CTL_MCLKSRC_BIT 23
`define CTL_DEEP_BIT 16
`define CTL_SDI_DIS_BIT 4
`define CTL_WSEL_LSB 10
`define CTL_WSEL_MSB 11
// audio configuration field positions
`define ACFG_ENABLE_BIT 7
`define ACFG_MONO_BIT 3
`define ACFG_IGN_TUR_BIT 8
`define ACFG_IGN_ROV_BIT 9
`define ACFG_TUR_EN_BIT 10
// status field positions
`define STAT_TUR_BIT 8
`define STAT_ROV_BIT 6
// values
`define AUD_I2S 2'h0
`define HALF_DIV 8'h13
`define FRAME32_LAST 6'h1f
`define FRAME64_LAST 6'h3f
`define HALF32_LAST 6'h0f
`define HALF64_LAST 6'h1f
`define HALF64_LEN 6'h20
`define HALF32_LEN 6'h10
`define DW16 6'h10
`define DW24 6'h18
`define DW32 6'h20
`define FIFO_DEEP 5'h10
`define FIFO_STD 5'h01
`define MCLK_HOLD 5'h1f
`endif

// [verilog/audio_stream_pkg.sv]
// types for the audio serial stream control block
`default_nettype none
package audio_stream_pkg;
   typedef enum logic [1:0] {
      WSEL_16_32 = 2'b00,
      WSEL_16_64 = 2'b01,
      WSEL_32_64 = 2'b10,
      WSEL_24_64 = 2'b11
   } width_sel_t;
   typedef enum logic {
      TX_RUN = 1'b0,
      TX_UNDERRUN = 1'b1
   } tx_state_t;
endpackage
`default_nettype wire

// [verilog/sync_two_stage.sv]
// two-flop level synchroniser
`default_nettype none
module sync_two_stage #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   // levels
   input wire logic [WIDTH-1:0] d,
   output logic [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   always_ff @(posedge clk) begin
      if (!rstn) begin
         meta <= '0;
         q <= '0;
      end else if (ce) begin
         meta <= d;
         q <= meta;
      end
   end
endmodule
`default_nettype wire

// [verilog/audio_word_fifo.sv]
// word fifo with selectable single or deep buffering
`include "audio_stream_regs.svh"
`default_nettype none
module audio_word_fifo (
   // clock, reset and depth select
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic deep,
   // fill side
   input wire logic wr_valid,
   input wire logic [31:0] wr_data,
   output logic wr_ready,
   // drain side
   output logic rd_valid,
   output logic [31:0] rd_data,
   input wire logic rd_ready,
   output logic [4:0] level
);
   logic [31:0] mem [16];
   logic [3:0] wp;
   logic [3:0] rp;
   logic [4:0] limit;
   logic [4:0] next_level;
   logic wr;
   logic rd;

   assign limit = deep ? `FIFO_DEEP : `FIFO_STD;
   assign wr = wr_valid & wr_ready;
   assign rd = rd_valid & rd_ready;
   assign next_level = level + {4'h0, wr} - {4'h0, rd};
   assign rd_data = mem[rp];

   always_ff @(posedge clk) begin
      if (wr && ce) begin
         mem[wp] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         wp <= 4'h0;
         rp <= 4'h0;
         level <= 5'h00;
         wr_ready <= 1'b0;
         rd_valid <= 1'b0;
      end else if (ce) begin
         if (wr) begin
            wp <= wp + 4'h1;
         end
         if (rd) begin
            rp <= rp + 4'h1;
         end
         level <= next_level;
         wr_ready <= next_level < limit;
         rd_valid <= next_level != 5'h00;
      end
   end
endmodule
`default_nettype wire

// [verilog/audio_serial_stream_control.sv]
// i2s audio stream engine with underrun and overflow handling
`include "audio_stream_regs.svh"
`default_nettype none
module audio_serial_stream_control (
   // clocks and reset
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic ce,
   input wire logic clk_mclk,
   // control
   input wire logic module_on,
   input wire logic master_role_enable,
   input wire logic master_clock_source_select,
   input wire logic deep_fifo_enable,
   input wire audio_stream_pkg::width_sel_t width_select,
   input wire logic serial_input_disable,
   input wire logic [1:0] audio_protocol_select,
   input wire logic audio_protocol_enable,
   input wire logic single_channel_replicate,
   input wire logic ignore_tx_underrun,
   input wire logic ignore_rx_overflow,
   input wire logic tx_underrun_error_enable,
   // status
   output logic tx_underrun_flag,
   input wire logic tx_underrun_clear,
   output logic rx_overflow_flag,
   input wire logic rx_overflow_clear,
   // transmit words
   input wire logic tx_valid,
   input wire logic [31:0] tx_data,
   output logic tx_ready,
   // receive words
   output logic rx_valid,
   output logic [31:0] rx_data,
   input wire logic rx_ready,
   // link pins
   input wire logic bclk_in,
   output logic bclk_out,
   output logic bclk_oe_n,
   input wire logic lrck_in,
   output logic lrck_out,
   output logic lrck_oe_n,
   output logic sdo,
   input wire logic sdi
);
   import audio_stream_pkg::*;

   logic run_n;
   logic active;
   logic master;
   logic [1:0] m_meta;
   logic [1:0] m_sync;
   logic mclk_tog;
   logic [4:0] rst_hold_cnt;
   logic mclk_run;
   logic [3:0] pin_s;
   logic bclk_s;
   logic lrck_s;
   logic sdi_s;
   logic tog_s;
   logic tog_prev;
   logic bclk_prev;
   logic mclk_edge;
   logic [7:0] div_cnt;
   logic half_tick;
   logic fall;
   logic rise;
   logic [5:0] bit_cnt;
   logic [5:0] frame_last;
   logic [5:0] half_last;
   logic [5:0] dwidth;
   logic [5:0] next_bit;
   logic [5:0] next_pos;
   logic [5:0] pos;
   logic next_ch;
   logic lrck_seen;
   logic load_pt;
   logic push_pt;
   tx_state_t tx_state;
   logic [31:0] sr;
   logic [31:0] hold;
   logic tx_pop;
   logic tur_evt;
   logic [31:0] tx_head;
   logic tx_head_valid;
   logic [4:0] tx_level;
   logic [31:0] rsr;
   logic rx_armed;
   logic dis_prev;
   logic rx_push;
   logic rx_fill_ready;

   function automatic logic [31:0] fmt_tx(input logic [31:0] w, input width_sel_t ws);
      case (ws)
         WSEL_32_64: fmt_tx = w;
         WSEL_24_64: fmt_tx = {w[23:0], 8'h00};
         default: fmt_tx = {w[15:0], 16'h0000};
      endcase
   endfunction

   function automatic logic [31:0] fmt_rx(input logic [31:0] w, input width_sel_t ws);
      case (ws)
         WSEL_32_64: fmt_rx = w;
         WSEL_24_64: fmt_rx = {8'h00, w[23:0]};
         default: fmt_rx = {16'h0000, w[15:0]};
      endcase
   endfunction

   assign run_n = rstn & module_on;
   assign active = module_on & audio_protocol_enable
      & (audio_protocol_select == `AUD_I2S);
   assign master = master_role_enable;

   // stretched reset so the slow master clock is sure to see it
   always_ff @(posedge clk_sys) begin
      if (!rstn) begin
         rst_hold_cnt <= 5'h00;
         mclk_run <= 1'b0;
      end else if (ce) begin
         if (rst_hold_cnt != `MCLK_HOLD) begin
            rst_hold_cnt <= rst_hold_cnt + 5'h01;
         end
         mclk_run <= (rst_hold_cnt == `MCLK_HOLD);
      end
   end

   // master clock domain: toggles once per rising mclk edge
   always_ff @(posedge clk_mclk) begin
      m_meta <= {mclk_run, ce};
      m_sync <= m_meta;
   end

   always_ff @(posedge clk_mclk) begin
      if (!m_sync[1]) begin
         mclk_tog <= 1'b0;
      end else if (m_sync[0]) begin
         mclk_tog <= ~mclk_tog;
      end
   end

   sync_two_stage #(.WIDTH(4)) u_pin_sync (
      .clk(clk_sys),
      .rstn(rstn),
      .ce(ce),
      .d({bclk_in, lrck_in, sdi, mclk_tog}),
      .q(pin_s)
   );
   assign {bclk_s, lrck_s, sdi_s, tog_s} = pin_s;

   always_ff @(posedge clk_sys) begin
      if (!run_n) begin
         tog_prev <= 1'b0;
         bclk_prev <= 1'b0;
      end else if (ce) begin
         tog_prev <= tog_s;
         bclk_prev <= bclk_s;
      end
   end
   assign mclk_edge = tog_s ^ tog_prev;

   // internal divider used when the system clock is the source
   always_ff @(posedge clk_sys) begin
      if (!run_n) begin
         div_cnt <= 8'h00;
      end else if (ce) begin
         if (!active || !master || master_clock_source_select || div_cnt == `HALF_DIV) begin
            div_cnt <= 8'h00;
         end else begin
            div_cnt <= div_cnt + 8'h01;
         end
      end
   end

   assign half_tick = active & master & (master_clock_source_select ? mclk_edge
      : (div_cnt == `HALF_DIV));
   assign fall = master ? (half_tick & bclk_out) : (active & bclk_prev & ~bclk_s);
   assign rise = master ? (half_tick & ~bclk_out) : (active & ~bclk_prev & bclk_s);

   // frame geometry
   always_comb begin
      frame_last = (width_select == WSEL_16_32) ? `FRAME32_LAST : `FRAME64_LAST;
      half_last = (width_select == WSEL_16_32) ? `HALF32_LAST : `HALF64_LAST;
      case (width_select)
         WSEL_32_64: dwidth = `DW32;
         WSEL_24_64: dwidth = `DW24;
         default: dwidth = `DW16;
      endcase
      if (!master && lrck_s != lrck_seen) begin
         next_bit = lrck_s ? ((width_select == WSEL_16_32) ? `HALF32_LEN : `HALF64_LEN) : 6'h00;
      end else if (bit_cnt == frame_last) begin
         next_bit = 6'h00;
      end else begin
         next_bit = (bit_cnt + 6'h01) & frame_last;
      end
      next_pos = next_bit & half_last;
      next_ch = (width_select == WSEL_16_32) ? next_bit[4] : next_bit[5];
      pos = bit_cnt & half_last;
      load_pt = fall & (next_pos == 6'h00);
      push_pt = fall & (next_pos == 6'h01);
   end

   // link clock, word select and pin direction
   always_ff @(posedge clk_sys) begin
      if (!run_n) begin
         bclk_out <= 1'b0;
         // idle high and last bit, so the first fall opens a left slot
         lrck_out <= 1'b1;
         bclk_oe_n <= 1'b1;
         lrck_oe_n <= 1'b1;
         bit_cnt <= `FRAME64_LAST;
         lrck_seen <= 1'b0;
      end else if (ce) begin
         bclk_oe_n <= ~(active & master);
         lrck_oe_n <= ~(active & master);
         if (half_tick) begin
            bclk_out <= ~bclk_out;
         end
         if (fall) begin
            bit_cnt <= next_bit;
            lrck_seen <= lrck_s;
            if (master) begin
               lrck_out <= next_ch;
            end
         end
      end
   end

   // transmit word selection
   always_comb begin
      tx_pop = 1'b0;
      tur_evt = 1'b0;
      if (load_pt) begin
         if (!next_ch || (tx_state == TX_RUN && !single_channel_replicate)) begin
            if (tx_head_valid) begin
               tx_pop = 1'b1;
            end else begin
               tur_evt = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!run_n) begin
         tx_state <= TX_RUN;
         sr <= 32'h0000_0000;
         hold <= 32'h0000_0000;
         sdo <= 1'b0;
      end else if (ce) begin
         if (load_pt) begin
            // a full slot's last bit goes out after the word select change
            sdo <= sr[31];
            if (tx_pop) begin
               sr <= fmt_tx(tx_head, width_select);
               hold <= tx_head;
            end else if (next_ch && tx_state == TX_RUN && single_channel_replicate) begin
               sr <= fmt_tx(hold, width_select);
            end else begin
               sr <= 32'h0000_0000;
            end
         end else if (fall) begin
            sdo <= sr[31];
            sr <= {sr[30:0], 1'b0};
         end
         case (tx_state)
            TX_RUN: begin
               if (tur_evt) begin
                  tx_state <= TX_UNDERRUN;
               end
            end
            TX_UNDERRUN: begin
               if (tx_pop && !next_ch) begin
                  tx_state <= TX_RUN;
               end
            end
            default: tx_state <= TX_RUN;
         endcase
      end
   end

   // error flags, set wins over clear
   always_ff @(posedge clk_sys) begin
      if (!run_n) begin
         tx_underrun_flag <= 1'b0;
      end else if (ce) begin
         if (tur_evt && tx_underrun_error_enable && !ignore_tx_underrun) begin
            tx_underrun_flag <= 1'b1;
         end else if (tx_underrun_clear) begin
            tx_underrun_flag <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!run_n) begin
         rx_overflow_flag <= 1'b0;
      end else if (ce) begin
         if (rx_push && !rx_fill_ready && !ignore_rx_overflow) begin
            rx_overflow_flag <= 1'b1;
         end else if (rx_overflow_clear) begin
            rx_overflow_flag <= 1'b0;
         end
      end
   end

   // receive shifter, independent of the replicate setting
   assign rx_push = push_pt & rx_armed & ~serial_input_disable;

   always_ff @(posedge clk_sys) begin
      if (!run_n) begin
         rsr <= 32'h0000_0000;
         rx_armed <= 1'b0;
         dis_prev <= 1'b0;
      end else if (ce) begin
         dis_prev <= serial_input_disable;
         // a full slot spills its last bit into the next slot
         if (rise && ((pos != 6'h00 && pos <= dwidth)
               || (pos == 6'h00 && dwidth == half_last + 6'h01))) begin
            rsr <= {rsr[30:0], sdi_s};
         end
         if (serial_input_disable || serial_input_disable != dis_prev) begin
            rx_armed <= 1'b0;
         end else if (push_pt && !next_ch) begin
            rx_armed <= 1'b1;
         end
      end
   end

   audio_word_fifo u_tx_fifo (
      .clk(clk_sys),
      .rstn(run_n),
      .ce(ce),
      .deep(deep_fifo_enable),
      .wr_valid(tx_valid),
      .wr_data(tx_data),
      .wr_ready(tx_ready),
      .rd_valid(tx_head_valid),
      .rd_data(tx_head),
      .rd_ready(tx_pop & ce),
      .level(tx_level)
   );

   audio_word_fifo u_rx_fifo (
      .clk(clk_sys),
      .rstn(run_n),
      .ce(ce),
      .deep(deep_fifo_enable),
      .wr_valid(rx_push & ce),
      .wr_data(fmt_rx(rsr, width_select)),
      .wr_ready(rx_fill_ready),
      .rd_valid(rx_valid),
      .rd_data(rx_data),
      .rd_ready(rx_ready),
      .level()
   );

   // checks
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!run_n);

   sequence left_load_s;
      load_pt && !next_ch;
   endsequence

   sequence underrun_fall_s;
      tx_state == TX_UNDERRUN && fall && !load_pt;
   endsequence

   proto_gate_a: assert property (!active ##1 !active |-> $stable(bclk_out))
      else $error("bit clock moved while audio protocol inactive");
   master_drive_a: assert property (ce && active && master |=> !bclk_oe_n && !lrck_oe_n)
      else $error("master does not drive link clocks");
   mclk_pace_a: assert property (master && master_clock_source_select && $changed(bclk_out)
      |-> $past(mclk_edge))
      else $error("bit clock not paced by master clock");
   sys_pace_a: assert property (master && !master_clock_source_select && $changed(bclk_out)
      |-> $past(div_cnt) == `HALF_DIV)
      else $error("bit clock not paced by divider");
   frame_len_a: assert property (master && fall && width_select == WSEL_16_32
      |=> bit_cnt <= `FRAME32_LAST)
      else $error("frame longer than 32 bits");
   std_depth_a: assert property (!deep_fifo_enable [*2] |-> tx_level <= `FIFO_STD)
      else $error("single buffer holds more than one word");
   mono_reuse_a: assert property (load_pt && next_ch && single_channel_replicate
      && tx_state == TX_RUN |-> !tx_pop)
      else $error("mono right channel consumed an entry");
   stereo_pop_a: assert property (load_pt && !single_channel_replicate && tx_state == TX_RUN
      && tx_head_valid |-> tx_pop)
      else $error("stereo channel did not consume an entry");
   zero_fill_a: assert property (ce ##0 underrun_fall_s |=> !sdo)
      else $error("nonzero data sent during underrun");
   resume_frame_a: assert property ($fell(tx_state == TX_UNDERRUN)
      |-> $past(load_pt && !next_ch))
      else $error("underrun left outside frame boundary");
   resume_load_a: assert property (ce ##0 left_load_s ##0 (tx_state == TX_UNDERRUN
      && tx_head_valid) |=> tx_state == TX_RUN)
      else $error("underrun kept although data waits at frame start");
   tur_set_a: assert property (ce && tur_evt && tx_underrun_error_enable && !ignore_tx_underrun
      |=> tx_underrun_flag)
      else $error("underrun flag not set");
   tur_ignore_a: assert property (ignore_tx_underrun && !tx_underrun_flag
      |=> !tx_underrun_flag)
      else $error("ignored underrun raised flag");
   rov_ignore_a: assert property (ignore_rx_overflow && !rx_overflow_flag
      |=> !rx_overflow_flag)
      else $error("ignored overflow raised flag");
   rx_dis_a: assert property (serial_input_disable |-> !rx_push)
      else $error("word stored while input disabled");
endmodule
`default_nettype wire

// [bench/codec_model.sv]
// serial audio codec model acting as link slave
`default_nettype none
module codec_model (
   // link
   input wire logic link_on,
   input wire logic bclk,
   input wire logic lrck,
   input wire logic sdo,
   output logic sdi
);
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [15:0] LEFT_WORD = 16'hc35a;
   localparam logic [15:0] RIGHT_WORD = 16'h5ac3;
   logic [15:0] tx_words [$];
   logic tx_right [$];
   logic [15:0] shift = 16'h0;
   logic [15:0] word;
   logic lr_prev = 1'b1;
   int idx = 63;
   int nxt;
   int cnt = 0;
   int frame_bits = 0;
   int rises = 0;
   initial sdi = 1'b0;
   // forget the old frame position when the master lets go of the link
   always @(negedge link_on) begin
      lr_prev = 1'b1;
      idx = 63;
   end
   // capture on rising bit clock; bits count from the last lrck change and may run past the next
   always @(posedge bclk) begin
      rises++;
      if (lrck == 1'b0 && lr_prev == 1'b1) begin
         frame_bits = cnt;
         cnt = 0;
      end
      cnt++;
      if (idx >= 0 && idx <= 15) begin
         shift = {shift[14:0], sdo};
         if (idx == 15) begin
            tx_words.push_back(shift);
            tx_right.push_back(lr_prev);
         end
      end
      idx = (lrck != lr_prev) ? 0 : idx + 1;
      lr_prev = lrck;
   end
   // drive on falling bit clock; past the word the line toggles so stray bits show
   always @(negedge bclk) begin
      #1;
      word = lr_prev ? RIGHT_WORD : LEFT_WORD;
      nxt = idx + 1;
      if (nxt >= 1 && nxt <= 16)
         sdi = word[16 - nxt];
      else
         sdi = ~sdi;
   end
endmodule
`default_nettype wire

// [bench/testbench.sv]
// self-checking bench for the audio serial stream control block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import audio_stream_pkg::*;
   logic clk_sys, rstn, ce, clk_mclk, module_on, master_role_enable;
   logic master_clock_source_select, deep_fifo_enable, serial_input_disable;
   width_sel_t width_select;
   logic [1:0] audio_protocol_select;
   logic audio_protocol_enable, single_channel_replicate, ignore_tx_underrun;
   logic ignore_rx_overflow, tx_underrun_error_enable, tx_underrun_flag, tx_underrun_clear;
   logic rx_overflow_flag, rx_overflow_clear, tx_valid, tx_ready, rx_valid, rx_ready;
   logic [31:0] tx_data, rx_data;
   logic bclk_out, bclk_oe_n, lrck_out, lrck_oe_n, sdo, sdi;
   wire bclk_w;
   wire lrck_w;
   logic [31:0] txw [4] = '{32'h00001234, 32'h0000abcd, 32'h00005678, 32'h0000ef01};
   int i, k, n;
   int cycles = 0;
   int bad_count = 0;
   int tests_run = 0;
   // pulled-down link lines
   assign bclk_w = bclk_oe_n ? 1'b0 : bclk_out;
   assign lrck_w = lrck_oe_n ? 1'b0 : lrck_out;
   audio_serial_stream_control uut (
      .clk_sys(clk_sys), .rstn(rstn), .ce(ce), .clk_mclk(clk_mclk),
      .module_on(module_on), .master_role_enable(master_role_enable),
      .master_clock_source_select(master_clock_source_select),
      .deep_fifo_enable(deep_fifo_enable), .width_select(width_select),
      .serial_input_disable(serial_input_disable),
      .audio_protocol_select(audio_protocol_select),
      .audio_protocol_enable(audio_protocol_enable),
      .single_channel_replicate(single_channel_replicate),
      .ignore_tx_underrun(ignore_tx_underrun), .ignore_rx_overflow(ignore_rx_overflow),
      .tx_underrun_error_enable(tx_underrun_error_enable),
      .tx_underrun_flag(tx_underrun_flag), .tx_underrun_clear(tx_underrun_clear),
      .rx_overflow_flag(rx_overflow_flag), .rx_overflow_clear(rx_overflow_clear),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
      .bclk_in(bclk_w), .bclk_out(bclk_out), .bclk_oe_n(bclk_oe_n),
      .lrck_in(lrck_w), .lrck_out(lrck_out), .lrck_oe_n(lrck_oe_n),
      .sdo(sdo), .sdi(sdi)
   );
   codec_model codec (
      .link_on(~bclk_oe_n), .bclk(bclk_w), .lrck(lrck_w), .sdo(sdo), .sdi(sdi)
   );
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   initial begin
      clk_mclk = 1'b0;
      #37;
      forever #62.5 clk_mclk = ~clk_mclk;
   end
   task automatic end_sim;
      if (bad_count == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
         bad_count++;
      end
   endtask
   task automatic pause(input int c);
      repeat (c) @(posedge clk_sys);
      #1;
   endtask
   task automatic wr(input logic [31:0] d);
      int w;
      w = 0;
      tx_valid = 1'b1;
      tx_data = d;
      do begin
         @(posedge clk_sys);
         w++;
      end while (tx_ready !== 1'b1 && w < 8000);
      if (tx_ready !== 1'b1) bad_count++;
      #1 tx_valid = 1'b0;
      pause(1);
   endtask
   task automatic rd(input logic [31:0] exp);
      int w;
      w = 0;
      rx_ready = 1'b1;
      do begin
         @(posedge clk_sys);
         w++;
      end while (rx_valid !== 1'b1 && w < 8000);
      if (rx_valid !== 1'b1) bad_count++;
      chk(rx_data, exp);
      #1 rx_ready = 1'b0;
      pause(1);
   endtask
   task automatic setup(input logic deep, input logic mono, input logic mck,
                        input width_sel_t ws);
      module_on = 1'b0;
      audio_protocol_enable = 1'b0;
      master_role_enable = 1'b0;
      deep_fifo_enable = deep;
      single_channel_replicate = mono;
      master_clock_source_select = mck;
      width_select = ws;
      pause(3);
      module_on = 1'b1;
      pause(3);
      codec.tx_words.delete();
      codec.tx_right.delete();
   endtask
   task automatic go;
      rx_overflow_clear = 1'b1;
      pause(1);
      rx_overflow_clear = 1'b0;
      audio_protocol_enable = 1'b1;
      master_role_enable = 1'b1;
   endtask
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 70000) begin
         bad_count++;
         end_sim();
      end
   end
   initial begin
      rstn = 1'b0; ce = 1'b1; module_on = 1'b0; master_role_enable = 1'b0;
      master_clock_source_select = 1'b1; deep_fifo_enable = 1'b1;
      width_select = WSEL_16_32; serial_input_disable = 1'b0;
      audio_protocol_select = 2'h1; audio_protocol_enable = 1'b0;
      single_channel_replicate = 1'b0; ignore_tx_underrun = 1'b0;
      ignore_rx_overflow = 1'b0; tx_underrun_error_enable = 1'b1;
      tx_underrun_clear = 1'b0; rx_overflow_clear = 1'b0;
      tx_valid = 1'b0; tx_data = 32'h0; rx_ready = 1'b0;
      pause(6);
      chk(tx_ready, 1'b0);
      chk(bclk_oe_n, 1'b1);
      rstn = 1'b1;
      // link stays idle with a wrong protocol select or without enable
      setup(1'b1, 1'b0, 1'b1, WSEL_16_32);
      go();
      pause(300);
      chk(bclk_oe_n, 1'b1);
      audio_protocol_select = 2'h0;
      audio_protocol_enable = 1'b0;
      pause(300);
      chk(lrck_oe_n, 1'b1);
      chk(codec.tx_words.size(), 0);
      // stereo from the mclk source, then underrun and frame-aligned resume
      setup(1'b1, 1'b0, 1'b1, WSEL_16_32);
      for (i = 0; i < 4; i++) wr(txw[i]);
      chk(tx_ready, 1'b1);
      go();
      pause(4200);
      chk(bclk_oe_n, 1'b0);
      chk(lrck_oe_n, 1'b0);
      for (i = 0; i < 4; i++) chk(codec.tx_words[i], txw[i]);
      chk(codec.tx_words[4], 32'h0);
      chk(codec.tx_words[5], 32'h0);
      chk(codec.frame_bits, 32);
      chk(tx_underrun_flag, 1'b1);
      n = codec.rises;
      pause(1000);
      chk((codec.rises - n) inside {[39:41]}, 1'b1);
      rd(32'h0000c35a);
      rd(32'h00005ac3);
      codec.tx_words.delete();
      codec.tx_right.delete();
      wr(32'h00002b2b);
      wr(32'h0000d4d4);
      pause(2500);
      k = 0;
      while (k < codec.tx_words.size() && codec.tx_words[k] == 16'h0) k++;
      chk(codec.tx_right[k], 1'b0);
      chk(codec.tx_words[k], 32'h00002b2b);
      chk(codec.tx_words[k + 1], 32'h0000d4d4);
      chk(tx_underrun_flag, 1'b1);
      module_on = 1'b0;
      pause(2);
      chk(tx_underrun_flag, 1'b0);
      // mono transmit, receive still stereo, underrun ignored
      ignore_tx_underrun = 1'b1;
      setup(1'b1, 1'b1, 1'b1, WSEL_16_32);
      wr(txw[0]);
      wr(txw[1]);
      go();
      rd(32'h0000c35a);
      rd(32'h00005ac3);
      pause(3000);
      for (i = 0; i < 4; i++) chk(codec.tx_words[i], txw[i / 2]);
      chk(tx_underrun_flag, 1'b0);
      // divider clock, 64-bit frame, single buffers, overflow and input disable
      setup(1'b0, 1'b0, 1'b0, WSEL_16_64);
      wr(txw[0]);
      chk(tx_ready, 1'b0);
      go();
      @(posedge bclk_out);
      n = 0;
      @(posedge clk_sys);
      while (bclk_out === 1'b1 && n < 100) begin
         n++;
         @(posedge clk_sys);
      end
      #1;
      chk(n, 20);
      pause(6000);
      chk(codec.frame_bits, 64);
      chk(rx_overflow_flag, 1'b1);
      ignore_rx_overflow = 1'b1;
      rx_overflow_clear = 1'b1;
      pause(1);
      rx_overflow_clear = 1'b0;
      pause(6000);
      chk(rx_overflow_flag, 1'b0);
      serial_input_disable = 1'b1;
      pause(3000);
      rd(32'h0000c35a);
      pause(6000);
      chk(rx_valid, 1'b0);
      serial_input_disable = 1'b0;
      rd(32'h0000c35a);
      end_sim();
   end
endmodule
`default_nettype wire
